// File: ast_regs.svh
// register offsets, field positions, reset values and timing figures of the serial transceiver
// assumes inclusion by the transceiver module, its monitor and the bench only
`ifndef AST_REGS_SVH
`define AST_REGS_SVH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define AST_DATA_IDX 8'h0C
`define AST_STATUS_IDX 8'h0B
`define AST_CONTROL_IDX 8'h0A
`define AST_BAUD_IDX 8'h09

// ------------------------------------------------------------
// status fields
// ------------------------------------------------------------
`define AST_ST_RXDONE 7
`define AST_ST_TXDONE 6
`define AST_ST_TXEMPTY 5
`define AST_ST_FRAMEERR 4
`define AST_ST_OVERRUN 3
`define AST_STATUS_RESET 8'h20

// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define AST_CT_RXIE 7
`define AST_CT_TXIE 6
`define AST_CT_EMPIE 5
`define AST_CT_RX_ENABLE_BIT 4
`define AST_CT_TX_ENABLE_BIT 3
`define AST_CT_NINE 2
`define AST_CT_RX_NINTH_BIT 1
`define AST_CT_TX_NINTH_BIT 0
`define AST_CONTROL_RESET 8'h02

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define AST_SAMPLES_PER_BIT 5'h10
`define AST_VOTE_FIRST 4'h7
`define AST_VOTE_LAST 4'h9
`define AST_BAUD_RESET 8'h00

`endif

// File: ast_pkg.sv
// types of the serial transceiver: receive state and pin bundles
// assumes ast_regs.svh sits in the include path
package ast_pkg;
   typedef enum logic [1:0] {
      AST_RX_IDLE = 2'b00,
      AST_RX_START = 2'b01,
      AST_RX_DATA = 2'b11,
      AST_RX_STOP = 2'b10
   } ast_rx_state_t;

   typedef struct packed {
      logic txOut;
      logic txOe;
      logic rxOe;
   } ast_pins_t;

   typedef struct packed {
      logic rxDone;
      logic txDone;
      logic txEmpty;
   } ast_irq_t;
endpackage

// File: ast_transceiver.sv
// full-duplex asynchronous serial transceiver with register port and line pins
// assumes a synchronous active-high reset and a one-cycle strobe register master
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
`include "ast_regs.svh"

module ast_transceiver (
   input wire logic refClk,
   input wire logic reset,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdata,
   input wire logic rxPin,
   input wire logic txVectorAck,
   input wire logic portPinZeroOut,
   input wire logic pinZeroDirection,
   input wire logic portPinOneOut,
   input wire logic pinOneDirection,
   output ast_pkg::ast_pins_t pins,
   output logic pinZeroPullup,
   output ast_pkg::ast_irq_t irq
);
   import ast_pkg::*;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic vote(input logic [2:0] s);
      vote = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction

   // ------------------------------------------------------------
   // register decode
   // ------------------------------------------------------------
   wire dataSel = (regAddr == `AST_DATA_IDX);
   wire statusSel = (regAddr == `AST_STATUS_IDX);
   wire controlSel = (regAddr == `AST_CONTROL_IDX);
   wire baudSel = (regAddr == `AST_BAUD_IDX);
   wire dataWrite = regWrite & dataSel;
   wire dataRead = regRead & dataSel;

   logic [7:0] controlReg;
   logic [7:0] baudReg;
   logic [7:0] txHoldReg;
   logic txHoldFullReg;
   logic [7:0] rxDataReg;
   logic rxDoneReg, txDoneReg, frameErrReg, overrunReg, overrunPendReg;

   // ------------------------------------------------------------
   // sample tick divider
   // ------------------------------------------------------------
   logic [7:0] divCnt_reg;
   wire tick = (divCnt_reg == baudReg);
   always_ff @(posedge refClk) begin
      if (reset || tick) divCnt_reg <= 8'h00;
      else divCnt_reg <= divCnt_reg + 8'h01;
   end

   // ------------------------------------------------------------
   // transmitter
   // ------------------------------------------------------------
   logic [10:0] txShift_reg;
   logic [3:0] txBits_reg;
   logic [3:0] txSub_reg;
   logic txBusy_reg;
   logic txLoaded_reg;
   logic txOut_reg;
   logic txPinEn_reg;
   wire tx_enable_bit = controlReg[`AST_CT_TX_ENABLE_BIT];
   wire nine = controlReg[`AST_CT_NINE];
   wire txBitTick = tick && (txSub_reg == 4'hF);
   wire txLastBit = (txBits_reg == (nine ? 4'hA : 4'h9));
   wire txFrameEnd = txBusy_reg && txBitTick && txLastBit;
   wire txIdleNow = !txBusy_reg || txFrameEnd;
   wire txLoad = txHoldFullReg && txIdleNow;
   wire [10:0] txFrame = nine ? {1'b1, controlReg[`AST_CT_TX_NINTH_BIT], txHoldReg, 1'b0}
                              : {2'b11, txHoldReg, 1'b0};

   always_ff @(posedge refClk) begin
      if (reset) begin
         txShift_reg <= 11'h7FF;
         txBits_reg <= 4'h0;
         txSub_reg <= 4'h0;
         txBusy_reg <= 1'b0;
         txLoaded_reg <= 1'b0;
         txOut_reg <= 1'b1;
      end else if (txLoad) begin
         txShift_reg <= txFrame;
         txBits_reg <= 4'h0;
         txSub_reg <= 4'h0;
         txBusy_reg <= 1'b1;
         txLoaded_reg <= 1'b1;
         txOut_reg <= txFrameEnd ? 1'b1 : txOut_reg;
      end else if (txBusy_reg && tick) begin
         txSub_reg <= txSub_reg + 4'h1;
         if (txLoaded_reg) begin
            txOut_reg <= txShift_reg[0];
            txLoaded_reg <= 1'b0;
            txSub_reg <= 4'h0;
         end else if (txBitTick) begin
            if (txLastBit) begin
               txBusy_reg <= 1'b0;
               txOut_reg <= 1'b1;
            end else begin
               txShift_reg <= {1'b1, txShift_reg[10:1]};
               txOut_reg <= txShift_reg[1];
               txBits_reg <= txBits_reg + 4'h1;
            end
         end
      end
   end

   // transmitter stays on the pin until both shifter and holding are drained
   always_ff @(posedge refClk) begin
      if (reset) txPinEn_reg <= 1'b0;
      else txPinEn_reg <= tx_enable_bit || txBusy_reg || txHoldFullReg;
   end

   // ------------------------------------------------------------
   // receiver front end and state machine
   // ------------------------------------------------------------
   logic rxMeta_reg, rxSyncA_reg, rxSyncB_reg, rxLine_reg;
   always_ff @(posedge refClk) begin
      if (reset) begin
         rxMeta_reg <= 1'b1;
         rxSyncA_reg <= 1'b1;
         rxSyncB_reg <= 1'b1;
         rxLine_reg <= 1'b1;
      end else begin
         rxMeta_reg <= rxPin;
         rxSyncA_reg <= rxMeta_reg;
         rxSyncB_reg <= rxSyncA_reg;
         if (rxSyncA_reg == rxSyncB_reg) rxLine_reg <= rxSyncB_reg;
      end
   end

   ast_rx_state_t rxState_reg;
   logic [3:0] rxSub_reg;
   logic [3:0] rxBits_reg;
   logic [2:0] rxVotes_reg;
   logic [8:0] rxShift_reg;
   wire rx_enable_bit = controlReg[`AST_CT_RX_ENABLE_BIT];
   wire [2:0] votesNow = {rxLine_reg, rxVotes_reg[2:1]};
   wire bitVal = vote(votesNow);
   wire atLastVote = tick && (rxSub_reg == `AST_VOTE_LAST);
   wire [3:0] rxNeed = nine ? 4'h8 : 4'h7;
   wire rxFinish = (rxState_reg == AST_RX_STOP) && atLastVote;
   wire stopOk = bitVal;
   wire [8:0] rxWord = nine ? rxShift_reg : {1'b0, rxShift_reg[8:1]};

   always_ff @(posedge refClk) begin
      if (reset || !rx_enable_bit) begin
         rxState_reg <= AST_RX_IDLE;
         rxSub_reg <= 4'h0;
         rxBits_reg <= 4'h0;
         rxVotes_reg <= 3'h0;
         rxShift_reg <= 9'h000;
      end else if (tick) begin
         rxSub_reg <= rxSub_reg + 4'h1;
         if (rxSub_reg >= `AST_VOTE_FIRST && rxSub_reg <= `AST_VOTE_LAST) rxVotes_reg <= votesNow;
         unique case (rxState_reg)
            AST_RX_IDLE: begin
               rxSub_reg <= 4'h1;
               if (!rxLine_reg) rxState_reg <= AST_RX_START;
            end
            AST_RX_START: if (atLastVote) begin
               if (bitVal) rxState_reg <= AST_RX_IDLE;
               else rxState_reg <= AST_RX_DATA;
               rxBits_reg <= 4'h0;
            end
            AST_RX_DATA: if (atLastVote) begin
               rxShift_reg <= {bitVal, rxShift_reg[8:1]};
               rxBits_reg <= rxBits_reg + 4'h1;
               if (rxBits_reg == rxNeed) rxState_reg <= AST_RX_STOP;
            end
            AST_RX_STOP: if (atLastVote) rxState_reg <= AST_RX_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // register write and receive hand-over decode
   // ------------------------------------------------------------
   wire controlWrite = regWrite && controlSel;
   wire baudWrite = regWrite && baudSel;
   wire statusWrite = regWrite && statusSel;
   wire txDoneWriteOne = statusWrite && regWdata[`AST_ST_TXDONE];
   wire txDoneSet = txFrameEnd && !txHoldFullReg;
   wire txDoneClear = txVectorAck || txDoneWriteOne;
   wire rxTake = rxFinish && !rxDoneReg;
   wire rxLost = rxFinish && rxDoneReg;
   wire rxNinthLoad = rxTake && nine;
   wire rxNinthNext = rxNinthLoad ? rxWord[8] : controlReg[`AST_CT_RX_NINTH_BIT];
   wire [7:0] controlWritten = {regWdata[7:2], rxNinthNext, regWdata[0]};

   // ------------------------------------------------------------
   // control and divisor registers
   // ------------------------------------------------------------
   // received ninth bit is read-only, so a control write keeps it
   always_ff @(posedge refClk) begin
      if (reset) begin
         controlReg <= `AST_CONTROL_RESET;
      end else if (controlWrite) begin
         controlReg <= controlWritten;
      end else begin
         controlReg[`AST_CT_RX_NINTH_BIT] <= rxNinthNext;
      end
   end

   always_ff @(posedge refClk) begin
      if (reset) begin
         baudReg <= `AST_BAUD_RESET;
      end else if (baudWrite) begin
         baudReg <= regWdata;
      end
   end

   // ------------------------------------------------------------
   // transmit holding register and its empty flag
   // ------------------------------------------------------------
   always_ff @(posedge refClk) begin
      if (reset) begin
         txHoldReg <= 8'h00;
      end else if (dataWrite) begin
         txHoldReg <= regWdata;
      end
   end

   // a write wins over the load of the previous character
   always_ff @(posedge refClk) begin
      if (reset) begin
         txHoldFullReg <= 1'b0;
      end else if (dataWrite) begin
         txHoldFullReg <= 1'b1;
      end else if (txLoad) begin
         txHoldFullReg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // transmit-done flag
   // ------------------------------------------------------------
   // hardware set wins over a clear in the same cycle
   always_ff @(posedge refClk) begin
      if (reset) begin
         txDoneReg <= 1'b0;
      end else if (txDoneSet) begin
         txDoneReg <= 1'b1;
      end else if (txDoneClear) begin
         txDoneReg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // receive data and status flags
   // ------------------------------------------------------------
   always_ff @(posedge refClk) begin
      if (reset) begin
         rxDataReg <= 8'h00;
      end else if (rxTake) begin
         rxDataReg <= rxWord[7:0];
      end
   end

   // a new character wins over the read that clears the flag
   always_ff @(posedge refClk) begin
      if (reset) begin
         rxDoneReg <= 1'b0;
      end else if (rxTake) begin
         rxDoneReg <= 1'b1;
      end else if (dataRead) begin
         rxDoneReg <= 1'b0;
      end
   end

   // framing error follows the stop bit of each character taken
   always_ff @(posedge refClk) begin
      if (reset) begin
         frameErrReg <= 1'b0;
      end else if (rxTake) begin
         frameErrReg <= !stopOk;
      end
   end

   // overrun shows on the read after the lost character
   always_ff @(posedge refClk) begin
      if (reset) begin
         overrunReg <= 1'b0;
      end else if (rxTake) begin
         overrunReg <= 1'b0;
      end else if (dataRead) begin
         overrunReg <= overrunPendReg;
      end
   end

   always_ff @(posedge refClk) begin
      if (reset) begin
         overrunPendReg <= 1'b0;
      end else if (rxLost) begin
         overrunPendReg <= 1'b1;
      end else if (dataRead) begin
         overrunPendReg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   wire [7:0] statusView = {rxDoneReg, txDoneReg, !txHoldFullReg, frameErrReg, overrunReg, 3'b000};
   wire [7:0] controlView = {controlReg[7:1], 1'b0};
   wire [7:0] readMux = dataSel ? rxDataReg : statusSel ? statusView : controlSel ? controlView
                        : baudSel ? baudReg : 8'h00;
   wire [7:0] regRdataNext = regRead ? readMux : 8'h00;

   always_ff @(posedge refClk) begin
      if (reset) begin
         regRdata <= 8'h00;
      end else begin
         regRdata <= regRdataNext;
      end
   end

   // ------------------------------------------------------------
   // pins
   // ------------------------------------------------------------
   wire pinZeroDriven = !rx_enable_bit & pinZeroDirection;
   wire txPinNext = txPinEn_reg ? txOut_reg : portPinOneOut;
   wire txOeNext = txPinEn_reg | pinOneDirection;
   wire rxOeNext = pinZeroDriven;
   wire pullupNext = portPinZeroOut & !pinZeroDriven;

   always_ff @(posedge refClk) begin
      if (reset) begin
         pins <= '{txOut: 1'b1, txOe: 1'b0, rxOe: 1'b0};
         pinZeroPullup <= 1'b0;
      end else begin
         pins.txOut <= txPinNext;
         pins.txOe <= txOeNext;
         pins.rxOe <= rxOeNext;
         pinZeroPullup <= pullupNext;
      end
   end

   // ------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------
   wire rxIrqNext = rxDoneReg & controlReg[`AST_CT_RXIE];
   wire txIrqNext = txDoneReg & controlReg[`AST_CT_TXIE];
   wire emptyIrqNext = !txHoldFullReg & controlReg[`AST_CT_EMPIE];

   always_ff @(posedge refClk) begin
      if (reset) begin
         irq <= '0;
      end else begin
         irq.rxDone <= rxIrqNext;
         irq.txDone <= txIrqNext;
         irq.txEmpty <= emptyIrqNext;
      end
   end
endmodule

// File: ast_transceiver_monitor.sv
// assertions on the transceiver ports
// assumes a bind onto ast_transceiver and a divisor written before the first frame
`timescale 1ns/100ps
`include "ast_regs.svh"
module ast_transceiver_monitor (
   input wire logic refClk,
   input wire logic reset,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regRdata,
   input wire logic txVectorAck,
   input ast_pkg::ast_pins_t pins,
   input ast_pkg::ast_irq_t irq
);
   import ast_pkg::*;
   logic [7:0] ctrlReg;
   logic [7:0] baudReg;
   int lowCnt;
   wire dataWr = regWrite && regAddr == `AST_DATA_IDX;
   default clocking @(posedge refClk); endclocking
   default disable iff (reset);
   // ------------------------------------------------------------
   // shadow registers and low run length on the transmit pin
   // ------------------------------------------------------------
   always_ff @(posedge refClk) begin
      if (reset) begin
         ctrlReg <= 8'h00;
         baudReg <= 8'h00;
         lowCnt <= 0;
      end else begin
         if (regWrite && regAddr == `AST_CONTROL_IDX) ctrlReg <= regWdata;
         if (regWrite && regAddr == `AST_BAUD_IDX) baudReg <= regWdata;
         lowCnt <= (pins.txOut || !pins.txOe) ? 0 : lowCnt + 1;
      end
   end
   a_read_window: assert property (!$past(regRead) |-> regRdata == 8'h00)
      else $error("read data outside its cycle");
   a_tx_pin_forced: assert property (ctrlReg[`AST_CT_TX_ENABLE_BIT] && $past(ctrlReg[`AST_CT_TX_ENABLE_BIT])
      && $past(ctrlReg[`AST_CT_TX_ENABLE_BIT], 2) |-> pins.txOe)
      else $error("tx pin not driven");
   a_rx_pin_input: assert property (ctrlReg[`AST_CT_RX_ENABLE_BIT] && $past(ctrlReg[`AST_CT_RX_ENABLE_BIT]) |-> !pins.rxOe)
      else $error("rx pin driven");
   a_bit_length: assert property ($rose(pins.txOut) && pins.txOe |-> lowCnt % (16 * (baudReg + 1)) == 0)
      else $error("low run not whole bits");
   a_empty_clear: assert property ($fell(irq.txEmpty) && ctrlReg[`AST_CT_EMPIE] && $past(ctrlReg[`AST_CT_EMPIE], 3)
      |-> $past(dataWr) || $past(dataWr, 2) || $past(dataWr, 3)) else $error("empty drop without write");
   a_rx_irq_clear: assert property (irq.rxDone && regRead && regAddr == `AST_DATA_IDX |-> ##2 !irq.rxDone)
      else $error("rx irq not cleared");
   a_tx_done_w1c: assert property (irq.txDone && dataWr == 1'b0 && regWrite && regAddr == `AST_STATUS_IDX
      && regWdata[`AST_ST_TXDONE] |-> ##2 !irq.txDone) else $error("tx done not cleared");
   a_tx_vector_ack: assert property (irq.txDone && txVectorAck |-> ##2 !irq.txDone)
      else $error("tx done kept after ack");
   c_frame: cover property ($fell(pins.txOut) && pins.txOe);
   c_rx_irq: cover property ($rose(irq.rxDone));
   c_tx_irq: cover property ($rose(irq.txDone));
endmodule

// File: ast_line_partner.sv
// remote serial station: sends frames, collects frames sampled mid-bit
// assumes the bench sets bitLen and nineBits before traffic
`timescale 1ns/100ps
module ast_line_partner (
   input wire logic refClk,
   input wire logic txLine,
   output logic rxLine
);
   int bitLen = 16;
   bit nineBits = 1'b0;
   logic [9:0] gotQ[$];
   logic [9:0] word;
   initial rxLine = 1'b1;
   task automatic send(input logic [8:0] d, input logic stopBit);
      logic [10:0] f;
      f = nineBits ? {stopBit, d, 1'b0} : {1'b1, stopBit, d[7:0], 1'b0};
      for (int i = 0; i < (nineBits ? 11 : 10); i++) begin
         rxLine <= f[i];
         repeat (bitLen) @(posedge refClk);
      end
      rxLine <= 1'b1;
      repeat (bitLen) @(posedge refClk);
   endtask
   task automatic glitch(input int n);
      rxLine <= 1'b0;
      repeat (n) @(posedge refClk);
      rxLine <= 1'b1;
   endtask
   always begin
      @(negedge txLine);
      repeat (bitLen / 2) @(posedge refClk);
      word = 10'h000;
      for (int i = 0; i < (nineBits ? 10 : 9); i++) begin
         repeat (bitLen) @(posedge refClk);
         word[i] = txLine;
      end
      gotQ.push_back(word);
   end
endmodule

// File: tb_async_serial_transceiver.sv
// self-checking bench of the serial transceiver against a remote station
// assumes package, monitor and partner compiled first
`timescale 1ns/100ps
`include "ast_regs.svh"
module tb_async_serial_transceiver;
   import ast_pkg::*;
   logic refClk = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0, txVectorAck = 1'b0;
   logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, d;
   logic portPinZeroOut = 1'b0, pinZeroDirection = 1'b0, pinOneDirection = 1'b0, pinZeroPullup, rxPin;
   logic [31:0] rnd = 32'h0000DC8B;
   logic [9:0] expQ[$];
   ast_pins_t pins;
   ast_irq_t irq;
   int error_cnt = 0, checked = 0, cycles = 0;
   always #2.5 refClk = ~refClk;
   ast_transceiver u_ast_transceiver (.refClk(refClk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .rxPin(rxPin), .txVectorAck(txVectorAck),
      .portPinZeroOut(portPinZeroOut), .pinZeroDirection(pinZeroDirection), .portPinOneOut(1'b1),
      .pinOneDirection(pinOneDirection), .pins(pins), .pinZeroPullup(pinZeroPullup), .irq(irq));
   ast_line_partner u_ast_line_partner (.refClk(refClk), .txLine(pins.txOut), .rxLine(rxPin));
   // ------------------------------------------------------------
   // bus tasks and checking
   // ------------------------------------------------------------
   function automatic logic [7:0] xs();
      rnd = rnd ^ (rnd << 13);
      rnd = rnd ^ (rnd >> 17);
      rnd = rnd ^ (rnd << 5);
      return rnd[7:0];
   endfunction
   task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] w);
      @(posedge refClk);
      regAddr <= a;
      regWdata <= w;
      regWrite <= 1'b1;
      @(posedge refClk);
      regWrite <= 1'b0;
   endtask
   task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge refClk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge refClk);
      regRead <= 1'b0;
      #1 chk(what, exp, regRdata);
   endtask
   task automatic frames(input int n);
      repeat (n * 11 * u_ast_line_partner.bitLen + 40) @(posedge refClk);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   always @(posedge refClk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         stop_test();
      end
   end
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(posedge refClk);
      d = xs();
      reset <= 1'b0;
      portPinZeroOut <= d[0];
      pinZeroDirection <= d[1];
      pinOneDirection <= d[2];
      rdchk("status", `AST_STATUS_IDX, 8'h20);
      rdchk("control", `AST_CONTROL_IDX, 8'h02);
      rdchk("unmapped", 8'h3F, 8'h00);
      wr(`AST_BAUD_IDX, 8'h01);
      u_ast_line_partner.bitLen = 32;
      wr(`AST_CONTROL_IDX, 8'hF8);
      rdchk("control", `AST_CONTROL_IDX, 8'hFA);
      chk("pullup", portPinZeroOut, pinZeroPullup);
      chk("rx dir", 1'b0, pins.rxOe);
      chk("tx dir", 1'b1, pins.txOe);
      for (int i = 0; i < 2; i++) begin
         d = xs();
         expQ.push_back({2'b01, d});
         wr(`AST_DATA_IDX, d);
      end
      wr(`AST_CONTROL_IDX, 8'hF0);
      frames(3);
      chk("tx count", 10'd2, u_ast_line_partner.gotQ.size());
      while (expQ.size() > 0) chk("tx char", expQ.pop_front(), u_ast_line_partner.gotQ.pop_front());
      chk("tx done irq", 1'b1, irq.txDone);
      chk("empty irq", 1'b1, irq.txEmpty);
      rdchk("status", `AST_STATUS_IDX, 8'h60);
      @(posedge refClk);
      txVectorAck <= 1'b1;
      @(posedge refClk);
      txVectorAck <= 1'b0;
      wr(`AST_CONTROL_IDX, 8'hFD);
      u_ast_line_partner.nineBits = 1'b1;
      d = xs();
      wr(`AST_DATA_IDX, d);
      frames(1);
      chk("tx nine", {2'b11, d}, u_ast_line_partner.gotQ.pop_front());
      wr(`AST_STATUS_IDX, 8'h40);
      rdchk("status", `AST_STATUS_IDX, 8'h20);
      d = xs();
      u_ast_line_partner.send({1'b0, d}, 1'b1);
      rdchk("rx nine", `AST_DATA_IDX, d);
      rdchk("control", `AST_CONTROL_IDX, 8'hFC);
      wr(`AST_CONTROL_IDX, 8'hF8);
      u_ast_line_partner.nineBits = 1'b0;
      for (int i = 0; i < 2; i++) begin
         d = xs();
         u_ast_line_partner.send(d, i[0]);
         chk("rx irq", 1'b1, irq.rxDone);
         rdchk("status", `AST_STATUS_IDX, i ? 8'hA0 : 8'hB0);
         rdchk("rx data", `AST_DATA_IDX, d);
      end
      u_ast_line_partner.glitch(12);
      frames(1);
      rdchk("status", `AST_STATUS_IDX, 8'h20);
      d = xs();
      u_ast_line_partner.send(d, 1'b1);
      u_ast_line_partner.send(~d, 1'b1);
      rdchk("rx kept", `AST_DATA_IDX, d);
      rdchk("status", `AST_STATUS_IDX, 8'h28);
      u_ast_line_partner.send(d ^ 8'h5A, 1'b1);
      rdchk("rx next", `AST_DATA_IDX, d ^ 8'h5A);
      rdchk("status", `AST_STATUS_IDX, 8'h20);
      stop_test();
   end
endmodule
bind ast_transceiver ast_transceiver_monitor u_ast_transceiver_monitor (.refClk(refClk), .reset(reset),
   .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
   .txVectorAck(txVectorAck), .pins(pins), .irq(irq));
